/* pkg/errlog_defines.svh */
`ifndef ERRLOG_DEFINES_SVH
`define ERRLOG_DEFINES_SVH

// ----------------------------------------------------------------
// Sector layout
// ----------------------------------------------------------------
`define LOG_VERSION     8'h01
`define NUM_SLOTS       3'd5
`define LAST_SLOT       3'd4
`define REC_BASE        9'd2
`define REC_BYTES       9'd90
`define REC_LAST        7'd89
`define SNAP_LAST       4'd11
`define DESC_START      7'd60
`define VER_ADDR        9'd0
`define IDX_ADDR        9'd1
`define REC_END_ADDR    9'd451
`define CNT_LO_ADDR     9'd452
`define CNT_HI_ADDR     9'd453
`define CKSUM_ADDR      9'd511
`define ERR_CNT_MAX     16'hFFFF
`define RESET_CMD_CODE  8'h00
`define STATE_HI_NIBBLE 4'h0

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define SECTOR_LAST     12'h1FC
`define REG_CTRL        12'h200
`define REG_STATUS      12'h204
`define CTRL_RESET      2'b01
`define CTRL_ENABLE_BIT 0
`define CTRL_CLEAR_BIT  1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   100
`define MS_PERIOD_NS    1000000
`define MS_PER_HOUR     3600000

`endif

/* pkg/errlog_pkg.sv */
package errlog_pkg;

	// One command or reset snapshot
	typedef struct packed {
		logic [7:0]  devCtl;
		logic [7:0]  features;
		logic [7:0]  secCount;
		logic [7:0]  secNumber;
		logic [7:0]  cylLow;
		logic [7:0]  cylHigh;
		logic [7:0]  devHead;
		logic [7:0]  cmd;
		logic [31:0] stampMs;
		logic [3:0]  pwrState;
	} snap_t;

	typedef enum logic [0:0] {
		BUILD_IDLE,
		BUILD_WRITE
	} build_state_t;

endpackage

/* hw/sector_ram.sv */
`timescale 1ns/1ps

// Word-wide sector store, byte write enables, registered read
module sector_ram (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [3:0]  byteEn,
	input  wire logic [6:0]  wrWord,
	input  wire logic [31:0] wrData,
	input  wire logic [6:0]  rdWord,
	output logic      [31:0] rdData
);
	localparam int unsigned DEPTH = 128;

	logic [31:0] mem [DEPTH];

	// Write port: one byte lane at a time from the builder
	always_ff @(posedge clk) begin
		for (int l = 0; l < 4; l++) begin
			if (byteEn[l]) begin
				mem[wrWord][l*8 +: 8] <= wrData[l*8 +: 8];
			end
		end
	end

	// Read port: data appear one edge after the address
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdData <= 32'h0000_0000;
		end else begin
			rdData <= mem[rdWord];
		end
	end
endmodule // sector_ram

/* hw/errlog_builder.sv */
//
// Behaviour
// - Sector is 512 bytes: version, index, five 90-byte records, count, checksum.
// - Byte zero always reads 01h.
// - Five record slots hold the five latest errors reported while logging is enabled and no record is being written, circularly.
// - Slots fill in order; the sixth error overwrites the oldest slot.
// - Index byte names the slot holding the newest record.
// - Slots never written read back as zero bytes.
// - Record is five 12-byte snapshots then a 30-byte descriptor.
// - Last snapshot is the failing command; earlier ones precede it in order.
// - Missing earlier snapshots are zero filled.
// - Preceding snapshots may be reported as zero when not captured.
// - Snapshot bytes 0-6 hold task registers at command write, byte 7 the code.
// - Snapshot bytes 8-11 hold power-on milliseconds at acceptance, wrapping.
// - Descriptor byte 0 reserved; bytes 1-7 completion registers and status.
// - Descriptor bytes 8-26 hold vendor extended error information.
// - Descriptor byte 27 is the power state at command write or reset.
// - State low nibble codes 0-4 as listed; high nibble vendor chosen.
// - Descriptor bytes 28-29 hold lifetime hours, low byte first.
// - Lifetime hours are taken at command completion.
// - Error count totals device faults only and saturates.
// - Byte 511 makes the whole sector sum to zero.
//
`timescale 1ns/1ps
`include "errlog_defines.svh"

module errlog_builder #(
	parameter int unsigned CYCLES_PER_MS = `MS_PERIOD_NS / `CLK_PERIOD_NS,
	parameter int unsigned MS_PER_HOUR   = `MS_PER_HOUR
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Task file at command write or reset
	input  wire logic        cmdWrite,
	input  wire logic        resetEvent,
	input  wire logic [7:0]  devCtl,
	input  wire logic [7:0]  features,
	input  wire logic [7:0]  secCount,
	input  wire logic [7:0]  secNumber,
	input  wire logic [7:0]  cylLow,
	input  wire logic [7:0]  cylHigh,
	input  wire logic [7:0]  devHead,
	input  wire logic [7:0]  command,
	input  wire logic [3:0]  powerState,
	// Error completion
	input  wire logic        errReport,
	input  wire logic        errDevice,
	input  wire logic [7:0]  errError,
	input  wire logic [7:0]  errSecCount,
	input  wire logic [7:0]  errSecNumber,
	input  wire logic [7:0]  errCylLow,
	input  wire logic [7:0]  errCylHigh,
	input  wire logic [7:0]  errDevHead,
	input  wire logic [7:0]  errStatus,
	input  wire logic [7:0]  errExtCode,
	output logic             logBusy
);
	import errlog_pkg::*;

	logic [31:0]  msDiv_q;
	logic [31:0]  msCount_q;
	logic [31:0]  hourDiv_q;
	logic [15:0]  hours_q;
	logic         msTick;
	snap_t        hist_q [5];
	logic [2:0]   histCnt_q;
	snap_t        snap_d;
	snap_t        build_q [5];
	logic [2:0]   buildCnt_q;
	logic [7:0]   errInfo_q [8];
	logic [15:0]  errHours_q;
	logic [15:0]  errCount_q;
	build_state_t state_q;
	logic [6:0]   k_q;
	logic [2:0]   sIdx_q;
	logic [3:0]   bIdx_q;
	logic [8:0]   wrAddr_q;
	logic [2:0]   slot_q;
	logic [2:0]   nextSlot_q;
	logic [2:0]   idx_q;
	logic [4:0]   used_q;
	logic [7:0]   slotSum_q [5];
	logic [1:0]   ctrl_q;
	logic         startBuild;
	logic         clearLog;
	logic [7:0]   curByte;
	logic [3:0]   byteEn;
	logic [31:0]  ramData;
	logic [31:0]  readWord;
	logic [7:0]   checksum;
	logic         apbDone;
	logic         mapped;

	// ----------------------------------------------------------------
	// Time base
	// ----------------------------------------------------------------

	// Millisecond enable from the core clock
	assign msTick = (msDiv_q == 32'(CYCLES_PER_MS - 1));

	// Power-on milliseconds, free to wrap
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			msDiv_q   <= 32'h0000_0000;
			msCount_q <= 32'h0000_0000;
		end else begin
			msDiv_q <= msTick ? 32'h0000_0000 : msDiv_q + 32'h0000_0001;
			if (msTick) begin
				msCount_q <= msCount_q + 32'h0000_0001;
			end
		end
	end

	// Lifetime hours; saturate rather than fold back to a young age
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hourDiv_q <= 32'h0000_0000;
			hours_q   <= 16'h0000;
		end else if (msTick) begin
			if (hourDiv_q == 32'(MS_PER_HOUR - 1)) begin
				hourDiv_q <= 32'h0000_0000;
				if (hours_q != 16'hFFFF) begin
					hours_q <= hours_q + 16'h0001;
				end
			end else begin
				hourDiv_q <= hourDiv_q + 32'h0000_0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Command history
	// ----------------------------------------------------------------

	// Snapshot of the task file; a reset carries a fixed code
	always_comb begin
		snap_d.devCtl    = devCtl;
		snap_d.features  = features;
		snap_d.secCount  = secCount;
		snap_d.secNumber = secNumber;
		snap_d.cylLow    = cylLow;
		snap_d.cylHigh   = cylHigh;
		snap_d.devHead   = devHead;
		snap_d.cmd       = cmdWrite ? command : `RESET_CMD_CODE;
		snap_d.stampMs   = msCount_q;
		snap_d.pwrState  = powerState;
	end

	// Newest entry sits at index 4, oldest at index 0
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 5; i++) begin
				hist_q[i] <= '0;
			end
			histCnt_q <= 3'd0;
		end else if (cmdWrite || resetEvent) begin
			for (int i = 0; i < 4; i++) begin
				hist_q[i] <= hist_q[i+1];
			end
			hist_q[4] <= snap_d;
			if (histCnt_q != `NUM_SLOTS) begin
				histCnt_q <= histCnt_q + 3'd1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Error capture and count
	// ----------------------------------------------------------------

	// A report while a record is still being written is dropped
	assign startBuild = errReport && ctrl_q[`CTRL_ENABLE_BIT] &&
		(state_q == BUILD_IDLE);

	// Freeze history and completion registers so later commands
	// cannot tear the record while it is being written
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 5; i++) begin
				build_q[i] <= '0;
			end
			for (int i = 0; i < 8; i++) begin
				errInfo_q[i] <= 8'h00;
			end
			buildCnt_q <= 3'd0;
			errHours_q <= 16'h0000;
		end else if (startBuild) begin
			build_q      <= hist_q;
			buildCnt_q   <= histCnt_q;
			errInfo_q[0] <= errError;
			errInfo_q[1] <= errSecCount;
			errInfo_q[2] <= errSecNumber;
			errInfo_q[3] <= errCylLow;
			errInfo_q[4] <= errCylHigh;
			errInfo_q[5] <= errDevHead;
			errInfo_q[6] <= errStatus;
			errInfo_q[7] <= errExtCode;
			errHours_q   <= hours_q;
		end
	end

	// Faulty host commands are not counted
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			errCount_q <= 16'h0000;
		end else if (errReport && errDevice &&
			errCount_q != `ERR_CNT_MAX) begin
			errCount_q <= errCount_q + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Record builder
	// ----------------------------------------------------------------

	// Byte k of the record under construction
	always_comb begin
		curByte = 8'h00;
		if (k_q < `DESC_START) begin
			// Earliest snapshots are empty when history is short
			// Only captured predecessors are shown, the rest stay zero
			if ({1'b0, sIdx_q} >= 4'd5 - {1'b0, buildCnt_q}) begin
				case (bIdx_q)
					4'd0:    curByte = build_q[sIdx_q].devCtl;
					4'd1:    curByte = build_q[sIdx_q].features;
					4'd2:    curByte = build_q[sIdx_q].secCount;
					4'd3:    curByte = build_q[sIdx_q].secNumber;
					4'd4:    curByte = build_q[sIdx_q].cylLow;
					4'd5:    curByte = build_q[sIdx_q].cylHigh;
					4'd6:    curByte = build_q[sIdx_q].devHead;
					4'd7:    curByte = build_q[sIdx_q].cmd;
					4'd8:    curByte = build_q[sIdx_q].stampMs[7:0];
					4'd9:    curByte = build_q[sIdx_q].stampMs[15:8];
					4'd10:   curByte = build_q[sIdx_q].stampMs[23:16];
					4'd11:   curByte = build_q[sIdx_q].stampMs[31:24];
					default: curByte = 8'h00;
				endcase
			end
		end else begin
			case (k_q - `DESC_START)
				7'd0:    curByte = 8'h00;
				7'd1:    curByte = errInfo_q[0];
				7'd2:    curByte = errInfo_q[1];
				7'd3:    curByte = errInfo_q[2];
				7'd4:    curByte = errInfo_q[3];
				7'd5:    curByte = errInfo_q[4];
				7'd6:    curByte = errInfo_q[5];
				7'd7:    curByte = errInfo_q[6];
				7'd8:    curByte = errInfo_q[7];
				7'd27:   curByte = {`STATE_HI_NIBBLE, build_q[4].pwrState};
				7'd28:   curByte = errHours_q[7:0];
				7'd29:   curByte = errHours_q[15:8];
				default: curByte = 8'h00;
			endcase
		end
	end

	// Walk 90 bytes into the target slot, one per cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q    <= BUILD_IDLE;
			k_q        <= 7'd0;
			sIdx_q     <= 3'd0;
			bIdx_q     <= 4'd0;
			wrAddr_q   <= 9'd0;
			slot_q     <= 3'd0;
			nextSlot_q <= 3'd0;
			idx_q      <= 3'd0;
			used_q     <= 5'b00000;
			logBusy    <= 1'b0;
		end else begin
			case (state_q)
				BUILD_IDLE: begin
					if (clearLog) begin
						used_q     <= 5'b00000;
						idx_q      <= 3'd0;
						nextSlot_q <= 3'd0;
					end else if (startBuild) begin
						state_q  <= BUILD_WRITE;
						logBusy  <= 1'b1;
						k_q      <= 7'd0;
						sIdx_q   <= 3'd0;
						bIdx_q   <= 4'd0;
						slot_q   <= nextSlot_q;
						wrAddr_q <= `REC_BASE +
							9'(9'(nextSlot_q) * `REC_BYTES);
						// Slot reads zero until it is whole again
						used_q[nextSlot_q] <= 1'b0;
					end
				end
				BUILD_WRITE: begin
					wrAddr_q <= wrAddr_q + 9'd1;
					k_q      <= k_q + 7'd1;
					if (bIdx_q == `SNAP_LAST) begin
						bIdx_q <= 4'd0;
						sIdx_q <= sIdx_q + 3'd1;
					end else begin
						bIdx_q <= bIdx_q + 4'd1;
					end
					if (k_q == `REC_LAST) begin
						state_q        <= BUILD_IDLE;
						logBusy        <= 1'b0;
						used_q[slot_q] <= 1'b1;
						idx_q          <= slot_q + 3'd1;
						nextSlot_q     <= (slot_q == `LAST_SLOT) ?
							3'd0 : slot_q + 3'd1;
					end
				end
				default: begin
					state_q <= BUILD_IDLE;
					logBusy <= 1'b0;
				end
			endcase
		end
	end

	// Running byte sum per slot keeps the checksum cheap
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 5; i++) begin
				slotSum_q[i] <= 8'h00;
			end
		end else if (startBuild) begin
			slotSum_q[nextSlot_q] <= 8'h00;
		end else if (state_q == BUILD_WRITE) begin
			slotSum_q[slot_q] <= slotSum_q[slot_q] + curByte;
		end
	end

	// ----------------------------------------------------------------
	// Sector store
	// ----------------------------------------------------------------

	assign byteEn = (state_q == BUILD_WRITE) ?
		(4'b0001 << wrAddr_q[1:0]) : 4'b0000;

	sector_ram u_ram (
		.clk    (clk),
		.resetn (resetn),
		.byteEn (byteEn),
		.wrWord (wrAddr_q[8:2]),
		.wrData ({4{curByte}}),
		.rdWord (paddr[8:2]),
		.rdData (ramData)
	);

	// Sum of bytes 0-510 over the fixed fields and whole slots only
	always_comb begin
		logic [7:0] sum;
		sum = `LOG_VERSION + {5'b00000, idx_q} +
			errCount_q[7:0] + errCount_q[15:8];
		for (int i = 0; i < 5; i++) begin
			if (used_q[i]) begin
				sum = sum + slotSum_q[i];
			end
		end
		checksum = 8'h00 - sum;
	end

	// Overlay fixed fields and blank empty slots on the stored word
	always_comb begin
		logic [8:0] a;
		logic       live;
		a        = 9'd0;
		live     = 1'b0;
		readWord = 32'h0000_0000;
		for (int l = 0; l < 4; l++) begin
			a    = {paddr[8:2], 2'(l)};
			live = 1'b0;
			for (int s = 0; s < 5; s++) begin
				if (a >= `REC_BASE + 9'(9'(s) * `REC_BYTES) &&
					a < `REC_BASE + 9'(9'(s + 1) * `REC_BYTES)) begin
					live = used_q[s];
				end
			end
			if (a == `VER_ADDR) begin
				readWord[l*8 +: 8] = `LOG_VERSION;
			end else if (a == `IDX_ADDR) begin
				readWord[l*8 +: 8] = {5'b00000, idx_q};
			end else if (a <= `REC_END_ADDR) begin
				readWord[l*8 +: 8] = live ? ramData[l*8 +: 8] : 8'h00;
			end else if (a == `CNT_LO_ADDR) begin
				readWord[l*8 +: 8] = errCount_q[7:0];
			end else if (a == `CNT_HI_ADDR) begin
				readWord[l*8 +: 8] = errCount_q[15:8];
			end else if (a == `CKSUM_ADDR) begin
				readWord[l*8 +: 8] = checksum;
			end else begin
				readWord[l*8 +: 8] = 8'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------

	assign apbDone  = psel && penable && pready;
	assign mapped   = (paddr[1:0] == 2'b00) && (paddr <= `SECTOR_LAST ||
		paddr == `REG_CTRL || paddr == `REG_STATUS);
	assign clearLog = apbDone && pwrite && (paddr == `REG_CTRL) &&
		pwdata[`CTRL_CLEAR_BIT];

	// One wait state: the store needs an edge to present its word
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			// The sector is read-only to software
			pslverr <= !mapped || (pwrite && paddr <= `SECTOR_LAST);
			if (pwrite || !mapped) begin
				prdata <= 32'h0000_0000;
			end else if (paddr == `REG_CTRL) begin
				prdata <= {30'h0000_0000, 1'b0, ctrl_q[0]};
			end else if (paddr == `REG_STATUS) begin
				prdata <= {errCount_q, 7'h00, used_q, idx_q, logBusy};
			end else begin
				prdata <= readWord;
			end
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Control: logging enable; the clear bit is a self-clearing strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= `CTRL_RESET;
		end else if (apbDone && pwrite && paddr == `REG_CTRL) begin
			ctrl_q <= {1'b0, pwdata[`CTRL_ENABLE_BIT]};
		end
	end

endmodule // errlog_builder

/* tb/errlog_builder_properties.sv */
`timescale 1ns/1ps

module errlog_builder_properties (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        errReport,
	input wire logic        logBusy
);
	logic [6:0] busyLen_q;

	// ------------------------------------------------------------
	// Helper logic and properties
	// ------------------------------------------------------------
	// Length of the current busy run, so the 90-cycle write is exact
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busyLen_q <= 7'h00;
		end else begin
			busyLen_q <= logBusy ? busyLen_q + 7'h01 : 7'h00;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	one_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("APB answer not after one wait state");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr outside a completion");
	ro_sector_a: assert property (
		pready && pwrite && paddr <= 12'h1FC |-> pslverr)
		else $error("sector write not refused");
	sector_read_a: assert property (
		pready && !pwrite && paddr <= 12'h1FC && paddr[1:0] == 2'h0
		|-> !pslverr) else $error("sector read refused");
	version_a: assert property (
		pready && !pwrite && paddr == 12'h000 |-> prdata[7:0] == 8'h01)
		else $error("version byte wrong");
	index_range_a: assert property (
		pready && !pwrite && paddr == 12'h000 |-> prdata[15:8] <= 8'h05)
		else $error("index byte out of range");
	reserved_zero_a: assert property (
		pready && !pwrite && paddr >= 12'h1C8 && paddr <= 12'h1F8
		|-> prdata == 32'h0000_0000) else $error("reserved bytes not zero");
	reserved_tail_a: assert property (
		pready && !pwrite && paddr == 12'h1FC |-> prdata[23:0] == 24'h0)
		else $error("reserved tail not zero");
	busy_start_a: assert property ($rose(logBusy) |-> $past(errReport))
		else $error("busy without an error report");
	busy_len_a: assert property ($fell(logBusy) |-> busyLen_q == 7'h5A)
		else $error("record write not 90 cycles");

	// Main scenarios reached
	cover property (pready && pslverr);
	cover property ($fell(logBusy));
	cover property (pready && !pwrite && paddr == 12'h000);
endmodule // errlog_builder_properties

bind errlog_builder errlog_builder_properties u_errlog_builder_properties (
	.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .errReport(errReport), .logBusy(logBusy)
);

/* tb/apb_host.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// Host side that reads the log sector over APB
// ------------------------------------------------------------
module apb_host (
	input  wire logic        clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// Idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end

	// One transfer; the leading edge keeps back-to-back calls race free
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule // apb_host

/* tb/errlog_builder_test.sv */
`timescale 1ns/1ps

module errlog_builder_test;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, logBusy;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        cmdWrite = 1'b0, resetEvent = 1'b0, errReport = 1'b0;
	logic        errDevice = 1'b0;
	logic [3:0]  powerState = 4'h0;
	logic [7:0]  tf[8] = '{default: 8'h00};
	logic [7:0]  ev[8] = '{default: 8'h00};
	logic [7:0]  exp[512];
	logic [99:0] hist[$];
	logic [15:0] cnt = 16'h0000;
	int          n_mismatch = 0, tests_run = 0, cyc = 0;
	int          evN = 0, nErr = 0, slot = 0;

	// ------------------------------------------------------------
	// Clock, edge count and instances
	// ------------------------------------------------------------
	always #50 clk = ~clk;
	always @(posedge clk) cyc <= resetn ? cyc + 1 : 0;

	// Short counts: 4 cycles per ms, 3 ms per hour
	errlog_builder #(.CYCLES_PER_MS(4), .MS_PER_HOUR(3)) u_errlog_builder (
		.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmdWrite(cmdWrite),
		.resetEvent(resetEvent), .devCtl(tf[0]), .features(tf[1]),
		.secCount(tf[2]), .secNumber(tf[3]), .cylLow(tf[4]),
		.cylHigh(tf[5]), .devHead(tf[6]), .command(tf[7]),
		.powerState(powerState), .errReport(errReport),
		.errDevice(errDevice), .errError(ev[0]), .errSecCount(ev[1]),
		.errSecNumber(ev[2]), .errCylLow(ev[3]), .errCylHigh(ev[4]),
		.errDevHead(ev[5]), .errStatus(ev[6]), .errExtCode(ev[7]),
		.logBusy(logBusy));
	apb_host u_apb_host (.clk(clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	// Counts every comparison and reports a mismatch at once
	task automatic check(input logic [31:0] got, input logic [31:0] want);
		tests_run++;
		if (got !== want) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
		end
	endtask

	// Whole sector against the model image, checksum worked out here
	task automatic check_sector();
		logic [31:0] r;
		logic        e;
		logic [7:0]  sum;
		sum = 8'h00;
		for (int i = 0; i < 511; i++) sum += exp[i];
		exp[511] = -sum;
		for (int w = 0; w < 128; w++) begin
			u_apb_host.xfer(1'b0, 12'(w * 4), 32'h0, r, e);
			check(r, {exp[w*4+3], exp[w*4+2], exp[w*4+1], exp[w*4]});
		end
	endtask

	// Command or reset at an edge mid-ms, so the stamp is unambiguous
	task automatic event_pulse(input logic isCmd);
		logic [99:0] s;
		int          k;
		do @(posedge clk); while (cyc % 4 != 0);
		k = cyc + 2;
		s = '0;
		for (int i = 0; i < 8; i++) begin
			tf[i] <= 8'(evN * 16 + i + 1);
			s[i*8 +: 8] = (i < 7 || isCmd) ? 8'(evN * 16 + i + 1) : 8'h00;
		end
		s[64 +: 32] = 32'(k / 4);
		s[99:96] = 4'(evN % 5);
		powerState <= 4'(evN % 5);
		cmdWrite <= isCmd;
		resetEvent <= !isCmd;
		hist.push_back(s);
		@(posedge clk);
		cmdWrite <= 1'b0;
		resetEvent <= 1'b0;
		evN++;
	endtask

	// Error report mid-hour; builds the expected record when logged
	task automatic raise_error(input logic dev, input logic logd);
		logic [99:0] s;
		int          k;
		int          b;
		do @(posedge clk); while (cyc % 4 != 0 || (cyc + 2) / 4 % 3 != 1);
		k = cyc + 2;
		for (int i = 0; i < 8; i++) ev[i] <= 8'(nErr * 16 + i + 128);
		errReport <= 1'b1;
		errDevice <= dev;
		@(posedge clk);
		errReport <= 1'b0;
		do @(posedge clk); while (logBusy !== 1'b0);
		cnt = cnt + 16'(dev);
		{exp[453], exp[452]} = cnt;
		if (logd) begin
			b = 2 + slot * 90;
			for (int j = 0; j < 5; j++) begin
				s = hist.size() >= 5 - j ? hist[hist.size() - 5 + j] : '0;
				for (int i = 0; i < 12; i++) exp[b+j*12+i] = s[i*8 +: 8];
			end
			for (int i = 0; i < 30; i++) begin
				exp[b+60+i] = (i > 0 && i < 9) ? 8'(nErr*16+i+127) : 8'h00;
			end
			exp[b+87] = {4'h0, s[99:96]};
			{exp[b+89], exp[b+88]} = 16'(k / 12);
			slot = (slot + 1) % 5;
			exp[1] = 8'(slot == 0 ? 5 : slot);
		end
		nErr++;
	endtask

	// Prints the counts and the verdict, then ends the run
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Whole run needs a few thousand cycles
	initial begin
		#2000000;
		n_mismatch++;
		complete_run();
	end

	// Main sequence
	initial begin
		logic [31:0] r;
		logic        e;
		foreach (exp[i]) exp[i] = 8'h00;
		exp[0] = 8'h01;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		check_sector();
		$display("Test empty sector done");
		u_apb_host.xfer(1'b0, 12'h300, 32'h0, r, e);
		check({31'h0, e}, 32'h1);
		u_apb_host.xfer(1'b1, 12'h010, 32'hFF, r, e);
		check({31'h0, e}, 32'h1);
		repeat (3) event_pulse(1'b1);
		raise_error(1'b1, 1'b1);
		check_sector();
		$display("Test first record done");
		u_apb_host.xfer(1'b1, 12'h200, 32'h0, r, e);
		raise_error(1'b1, 1'b0);
		u_apb_host.xfer(1'b1, 12'h200, 32'h1, r, e);
		for (int n = 0; n < 5; n++) begin
			event_pulse(n != 2);
			raise_error(n != 1, 1'b1);
		end
		check_sector();
		$display("Test wrap done");
		u_apb_host.xfer(1'b0, 12'h204, 32'h0, r, e);
		check(r, {cnt, 7'h00, 5'h1F, exp[1][2:0], 1'b0});
		u_apb_host.xfer(1'b1, 12'h200, 32'h3, r, e);
		u_apb_host.xfer(1'b0, 12'h200, 32'h0, r, e);
		check(r, 32'h0000_0001);
		u_apb_host.xfer(1'b0, 12'h204, 32'h0, r, e);
		check(r, {cnt, 16'h0000});
		$display("Test status and clear done");
		complete_run();
	end
endmodule // errlog_builder_test
